// ===== hdl/ksp_top.sv
// Keyscan and port configuration top with register access port
// Notes on behaviour
// RL1 - Pull-ups on both input ports stay enabled in every mode.
// RL2 - Four cathode outputs strobe low in turn, one 320 us slot each.
// RL3 - Strobe low time follows intensity, 1/64 to 63/64 of the slot.
// RL4 - Eight keys only with four digits; otherwise two keys per digit.
// RL5 - Scan cycle repeats forever; each key fully debounced within about 41 ms.
// RL6 - Key released before, pressed in both samples now, is debounced; raises interrupt.
// RL7 - Any combination of simultaneous keys is detected each cycle.
// RL8 - Config bits 4 and 3 pick keyscan or logic input per port.
// RL9 - Both ports keyscan gives eight keys, one port gives four.
// RL10 - Config bits 7..5 pick shared pin role: low, high, IRQ, segment.
// RL11 - Open-drain shared pin driven by interrupt logic or host level.
// RL12 - Config read returns role, port bits, live port levels, interrupt flag.
// RL13 - Interrupt flag readable so host can poll key events.
// RL14 - Debounced bit set once its key debounced since last read.
// RL15 - Debounced read clears after data returned; bits accumulate by OR.
// RL16 - Debounced read also releases the interrupt.
// RL17 - Held key reports once; must be released before debouncing again.
// RL18 - Writes to the debounced register are ignored.
// RL19 - Pressed bits show the latest scan test result.
// RL20 - Pressed read has no side effect on any register or interrupt.
// RL21 - Writes to the pressed register are ignored.
// RL22 - Host reads debounced register after each interrupt, before next cycle ends.
// RL23 - Scan limit bounds both digits strobed and keys sampled.
// RL24 - Key number k maps to data bit k in both key registers.
module ksp_top #(
  parameter int SLICE_CYCLES = ksp_pkg::SLICE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [1:0] scan_limit,
  input wire logic [5:0] intensity,
  input wire logic first_input_port,
  input wire logic second_input_port,
  output logic [1:0] input_pullup_en,
  output logic cathode_strobe_0,
  output logic cathode_strobe_1,
  output logic cathode_strobe_2,
  output logic cathode_strobe_3,
  output logic shared_interrupt_segment_pin_out,
  output logic shared_interrupt_segment_pin_oe,
  output logic seg_driver_select
);
  ksp_scan_if scan ();
  logic [4:0] port_cfg;
  logic [7:0] key_debounced;
  logic irq_flag;
  logic [7:0] pressed;
  logic [7:0] new_deb;
  // ----------------------------------------
  // Strobe sequencer and debouncer
  // ----------------------------------------
  ksp_strobe_gen #(
    .SLICE_CYCLES(SLICE_CYCLES)
  ) u_gen (
    .sys_clk(sys_clk),
    .rst(rst),
    .scan_limit(scan_limit),
    .intensity(intensity),
    .scan(scan.gen)
  );
  ksp_key_debounce u_deb (
    .sys_clk(sys_clk),
    .rst(rst),
    .port_level({second_input_port, first_input_port}),
    .port_scan(port_cfg[ksp_pkg::CFG_SCAN2:ksp_pkg::CFG_SCAN1]),
    .scan(scan.user),
    .pressed(pressed),
    .new_deb(new_deb)
  );
  // RL2 - strobes straight from sequencer flops
  // RL23 - unscanned digits stay high
  assign cathode_strobe_0 = scan.strobe_n[0];
  assign cathode_strobe_1 = scan.strobe_n[1];
  assign cathode_strobe_2 = scan.strobe_n[2];
  assign cathode_strobe_3 = scan.strobe_n[3];
  // ----------------------------------------
  // Register access decode
  // ----------------------------------------
  wire rd_cfg = reg_rd && (reg_addr == ksp_pkg::ADDR_PORT_CFG);
  wire rd_deb = reg_rd && (reg_addr == ksp_pkg::ADDR_DEBOUNCED);
  wire rd_prs = reg_rd && (reg_addr == ksp_pkg::ADDR_PRESSED);
  // RL18 - debounced address not writable
  // RL21 - pressed address not writable
  wire wr_cfg = reg_wr && (reg_addr == ksp_pkg::ADDR_PORT_CFG);
  wire any_new = (new_deb != ksp_pkg::KEYS_NONE);
  // RL8 - per-port role from write
  // RL10 - pin role from write
  wire [4:0] next_port_cfg = wr_cfg ? reg_wdata[ksp_pkg::WR_CFG_HI:ksp_pkg::WR_CFG_LO]
                                    : port_cfg;
  // RL14 - set on debounce
  // RL15 - clear after read, OR accumulate, set wins
  wire [7:0] next_debounced = (rd_deb ? ksp_pkg::KEYS_NONE : key_debounced) | new_deb;
  // RL6 - interrupt on new debounce
  // RL16 - debounced read releases interrupt
  wire next_irq = (irq_flag && !rd_deb) || any_new;
  // RL12 - config readback layout
  // RL13 - interrupt flag in bit 0
  wire [7:0] cfg_read = {port_cfg, second_input_port, first_input_port, irq_flag};
  // RL20 - pressed read returns data only
  wire [7:0] next_rdata = rd_cfg ? cfg_read :
                          rd_deb ? key_debounced :
                          rd_prs ? pressed : ksp_pkg::READ_NONE;
  // ----------------------------------------
  // Shared pin role decode
  // ----------------------------------------
  wire [2:0] role = port_cfg[ksp_pkg::CFG_ROLE_HI:ksp_pkg::CFG_ROLE_LO];
  wire role_seg = role[ksp_pkg::ROLE_SEG_BIT];
  // RL11 - open-drain from irq or host level
  wire next_pin_oe = role_seg ? 1'b0 :
                     (role == ksp_pkg::ROLE_DRIVE_LOW) ? 1'b1 :
                     (role == ksp_pkg::ROLE_DRIVE_HIGH) ? 1'b0 :
                     (role == ksp_pkg::ROLE_IRQ_LOW) ? next_irq : !next_irq;
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      port_cfg <= ksp_pkg::CFG_RESET;
      key_debounced <= ksp_pkg::KEYS_NONE;
      irq_flag <= 1'b0;
      reg_rdata <= ksp_pkg::READ_NONE;
      reg_rvalid <= 1'b0;
      input_pullup_en <= ksp_pkg::PULLUP_ON;
      shared_interrupt_segment_pin_out <= 1'b0;
      shared_interrupt_segment_pin_oe <= 1'b0;
      seg_driver_select <= 1'b1;
    end else begin
      port_cfg <= next_port_cfg;
      key_debounced <= next_debounced;
      irq_flag <= next_irq;
      reg_rdata <= next_rdata;
      reg_rvalid <= reg_rd;
      // RL1 - pull-ups always on
      input_pullup_en <= ksp_pkg::PULLUP_ON;
      shared_interrupt_segment_pin_out <= 1'b0;
      shared_interrupt_segment_pin_oe <= next_pin_oe;
      seg_driver_select <= role_seg;
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_pullup_always_on: assert property (input_pullup_en == ksp_pkg::PULLUP_ON) // RL1
    else $error("pull-up disabled");
  chk_scan_limit_strobe: assert property ( // RL23
    (scan_limit != 2'h3 && $stable(scan_limit)) [*2] |-> cathode_strobe_3)
    else $error("digit beyond scan limit strobed");
  chk_deb_read_clear: assert property (rd_deb && !any_new |=> // RL15
    key_debounced == ksp_pkg::KEYS_NONE && reg_rdata == $past(key_debounced))
    else $error("debounced read did not clear");
  chk_irq_on_event: assert property (any_new |=> irq_flag) // RL6
    else $error("interrupt not raised");
  chk_irq_read_clear: assert property (rd_deb && !any_new |=> !irq_flag) // RL16
    else $error("interrupt not released on read");
  chk_deb_write_ignore: assert property ( // RL18
    reg_wr && reg_addr == ksp_pkg::ADDR_DEBOUNCED && !reg_rd && !any_new
    |=> $stable(key_debounced))
    else $error("write changed debounced register");
  chk_prs_read_nofx: assert property (rd_prs && !any_new |=> // RL20
    $stable(irq_flag) && $stable(key_debounced))
    else $error("pressed read had side effect");
  chk_cfg_read_layout: assert property (rd_cfg |=> reg_rdata == // RL12
    {$past(port_cfg), $past(second_input_port), $past(first_input_port), $past(irq_flag)})
    else $error("config readback wrong");
  chk_cfg_write_ports: assert property (wr_cfg |=> // RL8
    port_cfg[ksp_pkg::CFG_SCAN2:ksp_pkg::CFG_SCAN1] == $past(reg_wdata[4:3]))
    else $error("port role not written");
  chk_pin_irq_low: assert property ( // RL11
    role == ksp_pkg::ROLE_IRQ_LOW && $stable(port_cfg)
    |-> shared_interrupt_segment_pin_oe == irq_flag)
    else $error("active-low interrupt pin wrong");
  chk_pin_drive_low: assert property ( // RL10
    role == ksp_pkg::ROLE_DRIVE_LOW && $stable(port_cfg)
    |-> shared_interrupt_segment_pin_oe && !seg_driver_select)
    else $error("logic-0 role not driving");
  chk_debounce_or: assert property (!rd_deb |=> // RL14
    (key_debounced & $past(key_debounced)) == $past(key_debounced))
    else $error("debounced bit lost without read");
  cov_key_debounced: cover property (any_new);
  cov_irq_pin_low: cover property (role == ksp_pkg::ROLE_IRQ_LOW && shared_interrupt_segment_pin_oe);
  cov_read_nonzero: cover property (rd_deb && key_debounced != ksp_pkg::KEYS_NONE);
endmodule

// ===== hdl/ksp_pkg.sv
// Shared constants for the keyscan and port configuration block
package ksp_pkg;
  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_PORT_CFG = 8'h06;
  localparam logic [7:0] ADDR_DEBOUNCED = 8'h08;
  localparam logic [7:0] ADDR_PRESSED = 8'h0C;
  localparam logic [7:0] READ_NONE = 8'h00;
  // ----------------------------------------
  // Port configuration fields (bits 7..3 stored)
  // ----------------------------------------
  localparam logic [4:0] CFG_RESET = 5'h10;
  localparam int CFG_ROLE_HI = 4;
  localparam int CFG_ROLE_LO = 2;
  localparam int CFG_SCAN2 = 1;
  localparam int CFG_SCAN1 = 0;
  localparam int WR_CFG_HI = 7;
  localparam int WR_CFG_LO = 3;
  localparam logic [2:0] ROLE_DRIVE_LOW = 3'h0;
  localparam logic [2:0] ROLE_DRIVE_HIGH = 3'h1;
  localparam logic [2:0] ROLE_IRQ_LOW = 3'h2;
  localparam logic [2:0] ROLE_IRQ_HIGH = 3'h3;
  localparam int ROLE_SEG_BIT = 2;
  localparam logic [1:0] PULLUP_ON = 2'h3;
  localparam logic [3:0] STROBE_IDLE = 4'hF;
  localparam logic [7:0] KEYS_NONE = 8'h00;
  // ----------------------------------------
  // Scan timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int SLOT_US = 320;
  localparam int SLICES_PER_SLOT = 64;
  localparam int SLICE_CYCLES =
    (SLOT_US * 1000 / SLICES_PER_SLOT + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIGITS_MAX = 4;
  localparam int DEBOUNCE_MS = 41;
  localparam int ROUNDS_PER_CYCLE = (DEBOUNCE_MS * 1000) / (SLOT_US * DIGITS_MAX);
  localparam logic [5:0] LAST_SLICE = 6'(SLICES_PER_SLOT - 1);
  localparam logic [5:0] FIRST_SLICE = 6'h00;
  localparam logic [4:0] LAST_ROUND = 5'(ROUNDS_PER_CYCLE - 1);
  localparam logic [4:0] TEST_ROUND_A = 5'h00;
  localparam logic [4:0] TEST_ROUND_B = 5'(ROUNDS_PER_CYCLE / 2);
  localparam logic [1:0] FIRST_DIGIT = 2'h0;
endpackage

// ===== hdl/ksp_scan_if.sv
// Scan timing carrier between strobe generator and key debouncer
interface ksp_scan_if;
  logic [3:0] strobe_n;
  logic [1:0] digit;
  logic sample;
  logic test;
  logic test_a;
  logic round_end;
  logic cycle_end;
  modport gen (
    output strobe_n, digit, sample, test, test_a, round_end, cycle_end
  );
  modport user (
    input strobe_n, digit, sample, test, test_a, round_end, cycle_end
  );
endinterface

// ===== hdl/ksp_strobe_gen.sv
// Cathode strobe sequencer with intensity duty and scan round timing
module ksp_strobe_gen #(
  parameter int SLICE_CYCLES = ksp_pkg::SLICE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [1:0] scan_limit,
  input wire logic [5:0] intensity,
  ksp_scan_if.gen scan
);
  localparam int CW = $clog2(SLICE_CYCLES + 1);
  logic [CW-1:0] tick;
  logic [5:0] slice;
  logic [1:0] digit;
  logic [4:0] round;
  // ----------------------------------------
  // Counter decode
  // ----------------------------------------
  wire slice_end = (tick == CW'(SLICE_CYCLES - 1));
  wire slot_end = slice_end && (slice == ksp_pkg::LAST_SLICE);
  // RL4 - keys follow digit count
  wire last_digit = (digit >= scan_limit);
  // RL23 - no strobe beyond limit
  wire in_limit = (digit <= scan_limit);
  wire round_end = slot_end && last_digit;
  wire is_test = (round == ksp_pkg::TEST_ROUND_A) || (round == ksp_pkg::TEST_ROUND_B);
  // RL3 - duty follows intensity
  wire [5:0] on_limit = (intensity == ksp_pkg::LAST_SLICE) ? ksp_pkg::LAST_SLICE - 6'h01
                                                            : intensity;
  // RL2 - one digit low
  wire [3:0] next_strobe_n = ((slice <= on_limit) && in_limit) ? ~(4'h1 << digit)
                                                              : ksp_pkg::STROBE_IDLE;
  // ----------------------------------------
  // Counters and outputs
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tick <= '0;
      slice <= '0;
      digit <= '0;
      round <= '0;
      scan.strobe_n <= ksp_pkg::STROBE_IDLE;
      scan.digit <= '0;
      scan.sample <= 1'b0;
      scan.test <= 1'b0;
      scan.test_a <= 1'b0;
      scan.round_end <= 1'b0;
      scan.cycle_end <= 1'b0;
    end else begin
      tick <= slice_end ? '0 : tick + CW'(1);
      slice <= slice_end ? slice + 6'h01 : slice;
      digit <= round_end ? ksp_pkg::FIRST_DIGIT : (slot_end ? digit + 2'h1 : digit);
      // RL5 - continuous cycle
      round <= !round_end ? round : (round == ksp_pkg::LAST_ROUND ? '0 : round + 5'h01);
      scan.strobe_n <= next_strobe_n;
      scan.digit <= digit;
      scan.sample <= slice_end && (slice == ksp_pkg::FIRST_SLICE);
      scan.test <= is_test;
      scan.test_a <= (round == ksp_pkg::TEST_ROUND_A);
      scan.round_end <= round_end;
      scan.cycle_end <= round_end && (round == ksp_pkg::LAST_ROUND);
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_one_strobe_low: assert property ($onehot0(~scan.strobe_n)) // RL2
    else $error("more than one strobe low");
  chk_blank_last_slice: assert property ( // RL3
    $past(slice) == ksp_pkg::LAST_SLICE |-> scan.strobe_n == ksp_pkg::STROBE_IDLE)
    else $error("strobe low in blanking slice");
endmodule

// ===== hdl/ksp_key_debounce.sv
// Two-sample key debouncer with per-key release tracking
module ksp_key_debounce (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [1:0] port_level,
  input wire logic [1:0] port_scan,
  ksp_scan_if.user scan,
  output logic [7:0] pressed,
  output logic [7:0] new_deb
);
  logic [7:0] collect;
  logic [7:0] first_seen;
  logic [7:0] both_seen;
  logic [7:0] prev_both;
  function automatic logic [7:0] put_key(input logic [7:0] v, input logic [2:0] idx,
                                         input logic b);
    logic [7:0] r;
    r = v;
    r[idx] = b;
    return r;
  endfunction
  // ----------------------------------------
  // Capture decode
  // ----------------------------------------
  wire [7:0] base = (scan.digit == ksp_pkg::FIRST_DIGIT) ? ksp_pkg::KEYS_NONE : collect;
  // RL9 - unassigned port masked
  wire key_lo = port_scan[ksp_pkg::CFG_SCAN1] & ~port_level[0];
  wire key_hi = port_scan[ksp_pkg::CFG_SCAN2] & ~port_level[1];
  // RL24 - key k on bit k
  wire [7:0] next_collect = put_key(put_key(base, {1'h0, scan.digit}, key_lo),
                                    {1'h1, scan.digit}, key_hi);
  // ----------------------------------------
  // Sampling and debounce
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      collect <= '0;
      pressed <= '0;
      first_seen <= '0;
      both_seen <= '0;
      prev_both <= '0;
      new_deb <= '0;
    end else begin
      // RL7 - all keys in parallel
      if (scan.sample && scan.test)
        collect <= next_collect;
      // RL19 - pressed tracks last test
      if (scan.round_end && scan.test) begin
        pressed <= collect;
        if (scan.test_a)
          first_seen <= collect;
        else
          both_seen <= first_seen & collect;
      end
      // RL6 - newly pressed in both samples
      // RL17 - re-arm only after release
      new_deb <= scan.cycle_end ? (both_seen & ~prev_both) : ksp_pkg::KEYS_NONE;
      if (scan.cycle_end)
        prev_both <= both_seen;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_held_key_once: assert property ((new_deb & $past(prev_both)) == ksp_pkg::KEYS_NONE) // RL17
    else $error("held key debounced again");
  chk_masked_port_keys: assert property ( // RL9
    !port_scan[ksp_pkg::CFG_SCAN1] && scan.sample && scan.test
    |=> collect[3:0] == 4'h0)
    else $error("logic-input port produced key");
endmodule

// ===== verif/ksp_key_matrix.sv
// Key switch matrix model on the cathode strobes and return lines
module ksp_key_matrix (
  input wire logic [3:0] strobe_n,
  input wire logic [7:0] key_down,
  output logic first_input_port,
  output logic second_input_port
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Return lines
  // ----------------------------------------
  // Pulled up; a closed switch on a low strobe pulls the line low
  assign first_input_port = ~|(key_down[3:0] & ~strobe_n);
  assign second_input_port = ~|(key_down[7:4] & ~strobe_n);
endmodule

// ===== verif/ksp_top_bench.sv
// Self-checking bench for the keyscan and port configuration top
module ksp_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, rst, reg_wr, reg_rd, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, key_down, rd;
  logic [1:0] scan_limit, input_pullup_en;
  logic [5:0] intensity;
  logic port1, port2, stb0, stb1, stb2, stb3, pin_out, pin_oe, seg_sel, stray;
  logic [2:0] roles [5] = '{3'h0, 3'h1, 3'h4, 3'h3, 3'h2};
  logic [1:0] role_exp [5] = '{2'h1, 2'h0, 2'h2, 2'h1, 2'h0};
  int n_fail, cmp_count;
  ksp_top #(.SLICE_CYCLES(4)) u_ksp_top (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .scan_limit(scan_limit), .intensity(intensity), .first_input_port(port1),
    .second_input_port(port2), .input_pullup_en(input_pullup_en),
    .cathode_strobe_0(stb0), .cathode_strobe_1(stb1), .cathode_strobe_2(stb2),
    .cathode_strobe_3(stb3), .shared_interrupt_segment_pin_out(pin_out),
    .shared_interrupt_segment_pin_oe(pin_oe), .seg_driver_select(seg_sel)
  );
  ksp_key_matrix u_ksp_key_matrix (
    .strobe_n({stb3, stb2, stb1, stb0}), .key_down(key_down),
    .first_input_port(port1), .second_input_port(port2)
  );
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    reg_addr <= addr;
    reg_wdata <= data;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
    @(posedge sys_clk);
    reg_addr <= addr;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check("read valid", {7'h00, reg_rvalid}, 8'h01);
    data = reg_rdata;
  endtask
  task automatic rd_chk(input string name, input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    reg_read(addr, d);
    check(name, d, exp);
  endtask
  task automatic wait_irq(input int limit);
    int i;
    for (i = 0; i < limit && pin_oe !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
      if (stb2 !== 1'b1 || stb3 !== 1'b1) stray = 1'b1;
    end
    if (i >= limit) begin
      n_fail++;
      $display("CHECK FAILED interrupt wait expected 1 seen 0");
      test_done();
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    scan_limit = 2'h3;
    intensity = 6'h20;
    key_down = 8'h00;
    stray = 1'b0;
    n_fail = 0;
    cmp_count = 0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset image and unmapped read
    rd_chk("port cfg reset", 8'h06, 8'h86);
    rd_chk("debounced reset", 8'h08, 8'h00);
    rd_chk("pressed reset", 8'h0C, 8'h00);
    rd_chk("unmapped", 8'h10, 8'h00);
    check("pullups", {6'h00, input_pullup_en}, 8'h03);
    $display("Test reset values done");
    // Read-only key registers
    reg_write(8'h08, 8'hFF);
    reg_write(8'h0C, 8'hFF);
    rd_chk("debounced write", 8'h08, 8'h00);
    rd_chk("pressed write", 8'h0C, 8'h00);
    // Shared pin roles, ending on active-low interrupt
    for (int r = 0; r < 5; r++) begin
      reg_write(8'h06, {roles[r], 5'h18});
      repeat (2) @(posedge sys_clk);
      #1;
      check("pin role", {6'h00, seg_sel, pin_oe}, {6'h00, role_exp[r]});
    end
    rd_chk("port cfg", 8'h06, 8'h5E);
    check("pullups keyscan", {6'h00, input_pullup_en}, 8'h03);
    check("pin out", {7'h00, pin_out}, 8'h00);
    $display("Test configuration done");
    // Two digits scanned, key 2 beyond the limit
    scan_limit <= 2'h1;
    key_down <= 8'h16;
    wait_irq(20000);
    // Second cycle end adds the key missed by the partial first cycle
    repeat (17000) @(posedge sys_clk);
    #1;
    check("strobe limit", {7'h00, stray}, 8'h00);
    rd_chk("pressed keys", 8'h0C, 8'h12);
    reg_read(8'h06, rd);
    check("irq flag", rd & 8'hF9, 8'h59);
    check("irq after pressed read", {7'h00, pin_oe}, 8'h01);
    rd_chk("pressed again", 8'h0C, 8'h12);
    rd_chk("debounced keys", 8'h08, 8'h12);
    repeat (2) @(posedge sys_clk);
    #1;
    check("irq cleared", {7'h00, pin_oe}, 8'h00);
    rd_chk("debounced cleared", 8'h08, 8'h00);
    $display("Test key press done");
    // Held key is not reported again
    scan_limit <= 2'h0;
    intensity <= 6'h3F;
    repeat (20000) @(posedge sys_clk);
    #1;
    check("held irq", {7'h00, pin_oe}, 8'h00);
    rd_chk("held debounced", 8'h08, 8'h00);
    $display("Test held key done");
    // Release, then first port as logic input
    key_down <= 8'h00;
    repeat (9000) @(posedge sys_clk);
    reg_write(8'h06, 8'h50);
    key_down <= 8'h11;
    wait_irq(20000);
    rd_chk("one port keys", 8'h08, 8'h10);
    $display("Test single port done");
    test_done();
  end
endmodule
